/* rtl/wdt_cnt.sv */
`default_nettype none

module wdt_cnt (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // control
  input  wire logic                      clr,
  input  wire logic                      tick,
  input  wire logic [4:0]                exp_sel,
  // state
  output logic [wdt_pkg::CNT_W-1:0]      cnt_q,
  output logic                           ovf_q
);

  logic [wdt_pkg::CNT_W-1:0] term;
  logic                      hit;
  logic [wdt_pkg::CNT_W-1:0] cnt_d;

  assign term  = (wdt_pkg::CNT_W'(1) << exp_sel) - wdt_pkg::CNT_W'(1);
  assign hit   = tick && (cnt_q == term) && !clr;
  // wrap on overflow so a missed service repeats every interval
  assign cnt_d = (clr || hit) ? '0 : (tick ? cnt_q + wdt_pkg::CNT_W'(1) : cnt_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ovf_q <= hit;
    end
  end

  property p_interval;
    @(posedge aclk) disable iff (!aresetn)
    ovf_q |-> ($past(cnt_q) == ((wdt_pkg::CNT_W'(1) << $past(exp_sel)) - wdt_pkg::CNT_W'(1)));
  endproperty
  a_interval: assert property (p_interval) else $error("overflow not at selected count");

endmodule

`default_nettype wire

/* rtl/wdt_pkg.sv */
`default_nettype none

package wdt_pkg;

  // register map, byte addresses on the 32-bit bus
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] WDT_MODE_OFS   = 4'h0;
  localparam logic [ADDR_W-1:0] WDT_CLEAR_OFS  = 4'h4;
  localparam logic [ADDR_W-1:0] WDT_STATUS_OFS = 4'h8;

  // reset values and special codes
  localparam logic [7:0] WDT_MODE_RST  = 8'h67;
  localparam logic [7:0] WDT_CLEAR_RST = 8'h9A;
  localparam logic [7:0] WDT_CLEAR_KEY = 8'hAC;
  localparam logic [7:0] WDT_MODE_OFF  = 8'h00;
  localparam logic [7:0] WDT_MODE_MASK = 8'h7F;

  // mode register fields
  localparam int unsigned WDT_ACT_HI_BIT = 6;
  localparam int unsigned WDT_ACT_LO_BIT = 5;
  localparam int unsigned WDT_SEL4_BIT   = 4;
  localparam int unsigned WDT_SEL3_BIT   = 3;
  localparam int unsigned WDT_SEL_LO_MSB = 2;

  // status register fields
  localparam int unsigned WDT_ST_WRITTEN_BIT = 0;
  localparam int unsigned WDT_ST_RUN_BIT     = 1;
  localparam int unsigned WDT_ST_OSCSW_BIT   = 2;
  localparam int unsigned WDT_ST_OVF_BIT     = 3;

  // interval exponents: period is 2^(base + n) count-clock ticks
  localparam int unsigned CNT_W = 26;
  localparam logic [4:0] WDT_EXP_OSC  = 5'h0C;
  localparam logic [4:0] WDT_EXP_MAIN = 5'h12;
  localparam logic [4:0] WDT_EXP_SUB  = 5'h09;

  // bus codes
  localparam logic [1:0] WDT_RESP_OKAY   = 2'h0;
  localparam logic [1:0] WDT_RESP_SLVERR = 2'h2;
  localparam logic [3:0] WDT_STRB_BYTE0  = 4'h1;

  typedef enum logic [1:0] {
    WDT_SRC_OSC,
    WDT_SRC_MAIN,
    WDT_SRC_SUB
  } wdt_src_t;

endpackage

`default_nettype wire

/* rtl/wdt_top.sv */
`default_nettype none

module wdt_top (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite write address
  input  wire logic [wdt_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic [2:0]                  awprot,
  input  wire logic                        awvalid,
  output logic                             awready,
  // axi4-lite write data
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  // axi4-lite write response
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  // axi4-lite read address
  input  wire logic [wdt_pkg::ADDR_W-1:0]  araddr,
  input  wire logic [2:0]                  arprot,
  input  wire logic                        arvalid,
  output logic                             arready,
  // axi4-lite read data
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // count-clock ticks, one aclk cycle each
  input  wire logic                        osc_tick,
  input  wire logic                        main_tick,
  input  wire logic                        sub_tick,
  // system state
  input  wire logic                        osc_stab,
  // requests
  output logic                             wd_reset_request,
  output logic                             wd_nmi_request,
  output logic                             cpu_clk_int_osc
);

  // bus channel state
  logic                       awready_q;
  logic                       awready_d;
  logic                       wready_q;
  logic                       wready_d;
  logic                       aw_full_q;
  logic                       aw_full_d;
  logic                       w_full_q;
  logic                       w_full_d;
  logic [wdt_pkg::ADDR_W-1:0] awaddr_q;
  logic [7:0]                 wdata_q;
  logic [3:0]                 wstrb_q;
  logic                       bvalid_q;
  logic                       bvalid_d;
  logic [1:0]                 bresp_q;
  logic                       arready_q;
  logic                       arready_d;
  logic                       rvalid_q;
  logic                       rvalid_d;
  logic [31:0]                rdata_q;
  logic [1:0]                 rresp_q;

  // watchdog state
  logic [7:0]                 mode_q;
  logic [7:0]                 clear_q;
  logic                       mode_written_q;
  logic                       run_q;
  logic                       rst_req_q;
  logic                       nmi_req_q;
  logic                       osc_sw_q;
  logic                       ovf_seen_q;
  logic [wdt_pkg::CNT_W-1:0]  cnt;
  logic                       ovf;

  // handshakes and decode
  logic                       aw_hs;
  logic                       w_hs;
  logic                       ar_hs;
  logic                       wr_do;
  logic                       wr_mode_sel;
  logic                       wr_clear_sel;
  logic                       wr_mapped;
  logic                       byte_ok;
  logic                       mode_we;
  logic                       clear_we;
  logic                       key_hit;
  logic                       rd_mode_sel;
  logic                       rd_clear_sel;
  logic                       rd_status_sel;
  logic                       rd_mapped;
  logic [7:0]                 status_val;
  logic [7:0]                 rd_byte;

  // counter control
  wdt_pkg::wdt_src_t          src;
  logic [4:0]                 exp_base;
  logic [4:0]                 exp_sel;
  logic                       tick;
  logic                       cnt_clr;
  logic                       act_hi;
  logic                       rst_fire;
  logic                       nmi_fire;
  logic                       sw_fire;

  // ---------------- write channel ----------------
  assign aw_hs = awvalid && awready_q;
  assign w_hs  = wvalid && wready_q;
  // address and data may come in either order; the write acts once both are held
  assign wr_do     = aw_full_q && w_full_q && !bvalid_q;
  assign aw_full_d = (aw_full_q || aw_hs) && !wr_do;
  assign w_full_d  = (w_full_q || w_hs) && !wr_do;
  assign bvalid_d  = wr_do || (bvalid_q && !bready);
  // one write in flight: no new address or data until the response is taken
  assign awready_d = !aw_full_d && !bvalid_d;
  assign wready_d  = !w_full_d && !bvalid_d;
  assign wr_mode_sel  = awaddr_q[wdt_pkg::ADDR_W-1:2] ==
                        wdt_pkg::WDT_MODE_OFS[wdt_pkg::ADDR_W-1:2];
  assign wr_clear_sel = awaddr_q[wdt_pkg::ADDR_W-1:2] ==
                        wdt_pkg::WDT_CLEAR_OFS[wdt_pkg::ADDR_W-1:2];
  assign wr_mapped    = wr_mode_sel || wr_clear_sel;
  // only a lone low-byte strobe counts as the byte access both registers need
  assign byte_ok      = wstrb_q == wdt_pkg::WDT_STRB_BYTE0;
  assign mode_we      = wr_do && wr_mode_sel && byte_ok && !mode_written_q;
  assign clear_we     = wr_do && wr_clear_sel && byte_ok;
  assign key_hit      = clear_we && (wdata_q == wdt_pkg::WDT_CLEAR_KEY);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      bvalid_q  <= 1'b0;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      bvalid_q  <= bvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= '0;
      wdata_q  <= 8'h00;
      wstrb_q  <= 4'h0;
      bresp_q  <= wdt_pkg::WDT_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awaddr_q <= awaddr;
      end
      if (w_hs) begin
        wdata_q <= wdata[7:0];
        wstrb_q <= wstrb;
      end
      // a late mode write is refused silently, a wrong width or address is an error
      if (wr_do) begin
        bresp_q <= (wr_mapped && byte_ok) ? wdt_pkg::WDT_RESP_OKAY : wdt_pkg::WDT_RESP_SLVERR;
      end
    end
  end

  // ---------------- read channel ----------------
  assign ar_hs     = arvalid && arready_q;
  assign rvalid_d  = ar_hs || (rvalid_q && !rready);
  assign arready_d = !rvalid_d;
  assign rd_mode_sel   = araddr[wdt_pkg::ADDR_W-1:2] ==
                         wdt_pkg::WDT_MODE_OFS[wdt_pkg::ADDR_W-1:2];
  assign rd_clear_sel  = araddr[wdt_pkg::ADDR_W-1:2] ==
                         wdt_pkg::WDT_CLEAR_OFS[wdt_pkg::ADDR_W-1:2];
  assign rd_status_sel = araddr[wdt_pkg::ADDR_W-1:2] ==
                         wdt_pkg::WDT_STATUS_OFS[wdt_pkg::ADDR_W-1:2];
  assign rd_mapped     = rd_mode_sel || rd_clear_sel || rd_status_sel;

  assign status_val = {4'h0, ovf_seen_q, osc_sw_q, run_q, mode_written_q};
  // mode stays readable any number of times
  assign rd_byte = rd_mode_sel  ? mode_q :
                   rd_clear_sel ? clear_q :
                   rd_status_sel ? status_val : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= wdt_pkg::WDT_RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      if (ar_hs) begin
        rdata_q <= {24'h00_0000, rd_byte};
        rresp_q <= rd_mapped ? wdt_pkg::WDT_RESP_OKAY : wdt_pkg::WDT_RESP_SLVERR;
      end
    end
  end

  // ---------------- registers ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q         <= wdt_pkg::WDT_MODE_RST;
      clear_q        <= wdt_pkg::WDT_CLEAR_RST;
      mode_written_q <= 1'b0;
      run_q          <= 1'b1;
    end else begin
      if (mode_we) begin
        mode_q         <= wdata_q & wdt_pkg::WDT_MODE_MASK;
        mode_written_q <= 1'b1;
        // the only write that may stop it is the one write itself
        run_q          <= wdata_q != wdt_pkg::WDT_MODE_OFF;
      end
      if (clear_we) begin
        clear_q <= wdata_q;
      end
    end
  end

  // ---------------- interval selection ----------------
  assign src = mode_q[wdt_pkg::WDT_SEL4_BIT] ? wdt_pkg::WDT_SRC_SUB :
               mode_q[wdt_pkg::WDT_SEL3_BIT] ? wdt_pkg::WDT_SRC_MAIN :
                                               wdt_pkg::WDT_SRC_OSC;

  always_comb begin
    exp_base = wdt_pkg::WDT_EXP_OSC;
    tick     = 1'b0;
    unique case (src)
      wdt_pkg::WDT_SRC_OSC: begin
        exp_base = wdt_pkg::WDT_EXP_OSC;
        tick     = osc_tick;
      end
      wdt_pkg::WDT_SRC_MAIN: begin
        exp_base = wdt_pkg::WDT_EXP_MAIN;
        tick     = main_tick;
      end
      wdt_pkg::WDT_SRC_SUB: begin
        exp_base = wdt_pkg::WDT_EXP_SUB;
        tick     = sub_tick;
      end
      default: begin
        exp_base = wdt_pkg::WDT_EXP_OSC;
        tick     = 1'b0;
      end
    endcase
  end

  assign exp_sel = exp_base + {2'b00, mode_q[wdt_pkg::WDT_SEL_LO_MSB:0]};
  // a new mode restarts the count so the old interval cannot fire under it
  assign cnt_clr = key_hit || mode_we || !run_q;

  wdt_cnt u_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (cnt_clr),
    .tick    (tick),
    .exp_sel (exp_sel),
    .cnt_q   (cnt),
    .ovf_q   (ovf)
  );

  // ---------------- overflow action ----------------
  assign act_hi   = mode_q[wdt_pkg::WDT_ACT_HI_BIT];
  assign rst_fire = ovf && act_hi && !osc_stab;
  assign nmi_fire = ovf && !act_hi;
  // during stabilisation a reset would loop, so fall back to the oscillator
  assign sw_fire  = ovf && act_hi && osc_stab;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_req_q  <= 1'b0;
      nmi_req_q  <= 1'b0;
      osc_sw_q   <= 1'b0;
      ovf_seen_q <= 1'b0;
    end else begin
      rst_req_q  <= rst_fire;
      nmi_req_q  <= nmi_fire;
      osc_sw_q   <= osc_sw_q || sw_fire;
      ovf_seen_q <= ovf_seen_q || ovf;
    end
  end

  // ---------------- outputs ----------------
  assign awready          = awready_q;
  assign wready           = wready_q;
  assign bvalid           = bvalid_q;
  assign bresp            = bresp_q;
  assign arready          = arready_q;
  assign rvalid           = rvalid_q;
  assign rdata            = rdata_q;
  assign rresp            = rresp_q;
  assign wd_reset_request = rst_req_q;
  assign wd_nmi_request   = nmi_req_q;
  assign cpu_clk_int_osc  = osc_sw_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_autostart;
    !$past(aresetn) |-> run_q && act_hi && !mode_written_q;
  endproperty
  a_autostart: assert property (p_autostart) else $error("not running in reset mode");
  property p_reset_vals;
    !$past(aresetn) |-> (mode_q == wdt_pkg::WDT_MODE_RST) && (clear_q == wdt_pkg::WDT_CLEAR_RST);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
  property p_mode_once;
    mode_written_q && wr_do && wr_mode_sel |=> $stable(mode_q) && run_q == $past(run_q);
  endproperty
  a_mode_once: assert property (p_mode_once) else $error("mode changed by second write");
  property p_mode_first;
    mode_we |=> mode_written_q && (mode_q == ($past(wdata_q) & wdt_pkg::WDT_MODE_MASK));
  endproperty
  a_mode_first: assert property (p_mode_first) else $error("first mode write lost");
  property p_run_locked;
    run_q && mode_written_q |=> run_q;
  endproperty
  a_run_locked: assert property (p_run_locked) else $error("watchdog stopped after write");
  property p_stop_on_zero;
    mode_we && wdata_q == wdt_pkg::WDT_MODE_OFF |=> !run_q ##1 (cnt == '0) && !ovf;
  endproperty
  a_stop_on_zero: assert property (p_stop_on_zero) else $error("zero mode did not stop");
  property p_key_clears;
    key_hit |=> cnt == '0;
  endproperty
  a_key_clears: assert property (p_key_clears) else $error("key did not clear counter");
  property p_rst_req;
    rst_fire |=> wd_reset_request && !wd_nmi_request ##1 !wd_reset_request;
  endproperty
  a_rst_req: assert property (p_rst_req) else $error("reset request wrong");
  property p_nmi_req;
    ovf && !act_hi |=> wd_nmi_request && !wd_reset_request;
  endproperty
  a_nmi_req: assert property (p_nmi_req) else $error("nmi request wrong");
  property p_no_req_without_ovf;
    !$past(ovf) |-> !wd_reset_request && !wd_nmi_request;
  endproperty
  a_no_req_without_ovf: assert property (p_no_req_without_ovf) else $error("spurious request");
  property p_stab_suppress;
    ovf && act_hi && osc_stab |=> !wd_reset_request && cpu_clk_int_osc;
  endproperty
  a_stab_suppress: assert property (p_stab_suppress) else $error("reset during stabilisation");
  property p_clear_byte;
    wr_do && wr_clear_sel && !byte_ok |=> $stable(clear_q) && bresp == wdt_pkg::WDT_RESP_SLVERR;
  endproperty
  a_clear_byte: assert property (p_clear_byte) else $error("wide clear write accepted");

endmodule

`default_nettype wire

/* verif/wdt_top_tb_top.sv */
`default_nettype none

module wdt_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // generous ceiling over the expected run of roughly 54k cycles
  localparam int unsigned TMO = 90000;

  logic                         aclk;
  logic                         aresetn;
  logic [wdt_pkg::ADDR_W-1:0]   awaddr;
  logic                         awvalid;
  logic                         awready;
  logic [31:0]                  wdata;
  logic [3:0]                   wstrb;
  logic                         wvalid;
  logic                         wready;
  logic [1:0]                   bresp;
  logic                         bvalid;
  logic                         bready;
  logic [wdt_pkg::ADDR_W-1:0]   araddr;
  logic                         arvalid;
  logic                         arready;
  logic [31:0]                  rdata;
  logic [1:0]                   rresp;
  logic                         rvalid;
  logic                         rready;
  logic                         osc_tick;
  logic                         main_tick;
  logic                         sub_tick;
  logic                         osc_stab;
  logic                         wd_reset_request;
  logic                         wd_nmi_request;
  logic                         cpu_clk_int_osc;
  int                           bad_count;
  int                           checked;
  int                           cyc;
  int                           n_rst;
  int                           n_nmi;
  logic [31:0]                  rd;
  logic [1:0]                   rsp;

  wdt_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .osc_tick(osc_tick), .main_tick(main_tick), .sub_tick(sub_tick),
    .osc_stab(osc_stab),
    .wd_reset_request(wd_reset_request), .wd_nmi_request(wd_nmi_request),
    .cpu_clk_int_osc(cpu_clk_int_osc)
  );

  initial begin
    aclk = 1'b0;
  end
  always #2.5 aclk = ~aclk;

  // request pulses are one cycle wide, so counting them catches doubles too
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (!aresetn) begin
      n_rst <= 0;
      n_nmi <= 0;
    end else begin
      if (wd_reset_request === 1'b1) n_rst <= n_rst + 1;
      if (wd_nmi_request === 1'b1) n_nmi <= n_nmi + 1;
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic do_reset(input logic stab);
    aresetn <= 1'b0;
    osc_stab <= stab;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
                        output logic [1:0] resp);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= s;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // one tick every other cycle; settle long enough for the two-flop request path
  task automatic ticks(input wdt_pkg::wdt_src_t src, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      osc_tick <= (src == wdt_pkg::WDT_SRC_OSC);
      main_tick <= (src == wdt_pkg::WDT_SRC_MAIN);
      sub_tick <= (src == wdt_pkg::WDT_SRC_SUB);
      @(posedge aclk);
      osc_tick <= 1'b0;
      main_tick <= 1'b0;
      sub_tick <= 1'b0;
    end
    repeat (4) @(posedge aclk);
  endtask

  task automatic t_reset_state();
    do_reset(1'b0);
    axi_rd(wdt_pkg::WDT_MODE_OFS, rd, rsp);
    check(rd, 32'h00000067);
    axi_rd(wdt_pkg::WDT_CLEAR_OFS, rd, rsp);
    check(rd, 32'h0000009A);
    axi_rd(wdt_pkg::WDT_STATUS_OFS, rd, rsp);
    check(rd, 32'h00000002);
    axi_wr(wdt_pkg::WDT_CLEAR_OFS, wdt_pkg::WDT_CLEAR_KEY, 4'hF, rsp);
    check(rsp, wdt_pkg::WDT_RESP_SLVERR);
    axi_wr(4'hC, 8'h11, 4'h1, rsp);
    check(rsp, wdt_pkg::WDT_RESP_SLVERR);
    axi_rd(4'hC, rd, rsp);
    check(rd, 32'h00000000);
    check(rsp, wdt_pkg::WDT_RESP_SLVERR);
    axi_wr(wdt_pkg::WDT_STATUS_OFS, 8'hFF, 4'h1, rsp);
    check(rsp, wdt_pkg::WDT_RESP_SLVERR);
    // confirming the defaults still uses up the one write
    axi_wr(wdt_pkg::WDT_MODE_OFS, wdt_pkg::WDT_MODE_RST, 4'h1, rsp);
    axi_rd(wdt_pkg::WDT_MODE_OFS, rd, rsp);
    check(rd, 32'h00000067);
    axi_rd(wdt_pkg::WDT_STATUS_OFS, rd, rsp);
    check(rd, 32'h00000003);
  endtask

  task automatic t_once_and_key();
    do_reset(1'b0);
    axi_wr(wdt_pkg::WDT_MODE_OFS, 8'h00, 4'hF, rsp);
    check(rsp, wdt_pkg::WDT_RESP_SLVERR);
    axi_wr(wdt_pkg::WDT_MODE_OFS, 8'h60, 4'h1, rsp);
    check(rsp, wdt_pkg::WDT_RESP_OKAY);
    axi_wr(wdt_pkg::WDT_MODE_OFS, 8'h00, 4'h1, rsp);
    check(rsp, wdt_pkg::WDT_RESP_OKAY);
    axi_rd(wdt_pkg::WDT_MODE_OFS, rd, rsp);
    check(rd, 32'h00000060);
    axi_rd(wdt_pkg::WDT_STATUS_OFS, rd, rsp);
    check(rd[1:0], 2'h3);
    ticks(wdt_pkg::WDT_SRC_OSC, 4000);
    // a wrong key must leave the count alone, so overflow lands on tick 4096
    axi_wr(wdt_pkg::WDT_CLEAR_OFS, 8'h55, 4'h1, rsp);
    ticks(wdt_pkg::WDT_SRC_OSC, 95);
    check(n_rst, 0);
    ticks(wdt_pkg::WDT_SRC_OSC, 1);
    check(n_rst, 1);
    // key lands mid-count, so only a real clear keeps the next overflow away
    ticks(wdt_pkg::WDT_SRC_OSC, 100);
    axi_wr(wdt_pkg::WDT_CLEAR_OFS, wdt_pkg::WDT_CLEAR_KEY, 4'h1, rsp);
    ticks(wdt_pkg::WDT_SRC_OSC, 4095);
    check(n_rst, 1);
    ticks(wdt_pkg::WDT_SRC_OSC, 1);
    check({n_rst[15:0], n_nmi[15:0]}, 32'h00020000);
  endtask

  task automatic t_nmi();
    do_reset(1'b0);
    axi_wr(wdt_pkg::WDT_MODE_OFS, 8'h20, 4'h1, rsp);
    ticks(wdt_pkg::WDT_SRC_OSC, 4096);
    check({n_rst[15:0], n_nmi[15:0]}, 32'h00000001);
  endtask

  task automatic t_sub_main();
    do_reset(1'b0);
    // subclock, shortest interval; bit 3 set to show it is ignored there
    axi_wr(wdt_pkg::WDT_MODE_OFS, 8'h58, 4'h1, rsp);
    ticks(wdt_pkg::WDT_SRC_OSC, 600);
    ticks(wdt_pkg::WDT_SRC_SUB, 511);
    check(n_rst, 0);
    ticks(wdt_pkg::WDT_SRC_SUB, 1);
    check(n_rst, 1);
    do_reset(1'b0);
    axi_wr(wdt_pkg::WDT_MODE_OFS, 8'h48, 4'h1, rsp);
    ticks(wdt_pkg::WDT_SRC_OSC, 4200);
    ticks(wdt_pkg::WDT_SRC_SUB, 600);
    check(n_rst, 0);
  endtask

  task automatic t_off();
    do_reset(1'b0);
    axi_wr(wdt_pkg::WDT_MODE_OFS, wdt_pkg::WDT_MODE_OFF, 4'h1, rsp);
    axi_wr(wdt_pkg::WDT_MODE_OFS, 8'h60, 4'h1, rsp);
    ticks(wdt_pkg::WDT_SRC_OSC, 4200);
    check({n_rst[15:0], n_nmi[15:0]}, 32'h0);
    axi_rd(wdt_pkg::WDT_STATUS_OFS, rd, rsp);
    check(rd[1:0], 2'h1);
  endtask

  task automatic t_stab();
    do_reset(1'b1);
    check(cpu_clk_int_osc, 1'b0);
    axi_wr(wdt_pkg::WDT_MODE_OFS, 8'h60, 4'h1, rsp);
    ticks(wdt_pkg::WDT_SRC_OSC, 4096);
    check({n_rst[7:0], 7'h0, cpu_clk_int_osc}, 16'h0001);
    axi_rd(wdt_pkg::WDT_STATUS_OFS, rd, rsp);
    check(rd, 32'h0000000F);
    osc_stab <= 1'b0;
  endtask

  initial begin
    bad_count = 0;
    checked = 0;
    aresetn = 1'b0;
    awaddr = 4'h0;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 4'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    osc_tick = 1'b0;
    main_tick = 1'b0;
    sub_tick = 1'b0;
    osc_stab = 1'b0;
    fork
      begin
        t_reset_state();
        t_once_and_key();
        t_nmi();
        t_sub_main();
        t_off();
        t_stab();
      end
      begin
        // running out of cycles counts as a mismatch
        wait (cyc >= TMO);
        bad_count = bad_count + 1;
      end
    join_any
    stop_test();
  end

endmodule

`default_nettype wire
